/* File: common/sicf_pkg.sv */
package sicf_pkg;
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned IDLE_TIME_MS  = 1000;
    localparam int unsigned IDLE_CYCLES   = CLK_HZ / 1000 * IDLE_TIME_MS;
    localparam int unsigned PERIOD_TIME_MS = 3000;
    localparam int unsigned PERIOD_CYCLES = CLK_HZ / 1000 * PERIOD_TIME_MS;
    // Ten equal slots: four blinks use eight, the last two stay dark
    localparam int unsigned SLOTS_PER_PERIOD = 10;
    localparam int unsigned CUR_W         = 8;
    localparam int unsigned IDLE_PCT      = 60;
    localparam int unsigned BLINK_OC      = 1;
    localparam int unsigned BLINK_OV      = 2;
    localparam int unsigned BLINK_PH      = 4;
    localparam int unsigned FLT_OC_BIT    = 0;
    localparam int unsigned FLT_OV_BIT    = 1;
    localparam int unsigned FLT_PH_BIT    = 2;
    localparam int unsigned FLT_W         = 3;
endpackage

/* File: rtl/sicf_sync.sv */
`timescale 1ns/100ps
// Two-flop synchroniser for one asynchronous level
module sicf_sync (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // Level
    input  wire logic i_d,
    output logic      o_q
);
    logic meta_q;

    // Only the second flop is read downstream
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            o_q    <= 1'b0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule

/* File: rtl/sicf_top.sv */
`timescale 1ns/100ps
module sicf_top
    import sicf_pkg::*;
#(
    parameter int unsigned IDLE_CNT   = IDLE_CYCLES,
    parameter int unsigned PERIOD_CNT = PERIOD_CYCLES
) (
    // Clock and power-on reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    // Controller and switches
    input  wire logic             i_step_pulse_input,
    input  wire logic             i_standstill_current_select_switch,
    input  wire logic [CUR_W-1:0] i_dynamic_current,
    // Fault detectors from the power stage
    input  wire logic             i_over_current,
    input  wire logic             i_over_voltage,
    input  wire logic             i_phase_error,
    // Power stage and indicator
    output logic [CUR_W-1:0]      o_current_target,
    output logic                  o_standstill_target_q_dummy,
    output logic                  o_bridge_enable,
    output logic                  o_red_led,
    output logic [FLT_W-1:0]      o_fault_latched
);
    localparam int unsigned SLOT_CNT = PERIOD_CNT / SLOTS_PER_PERIOD;

    logic             step_s;
    logic             sw_s;
    logic             oc_s;
    logic             ov_s;
    logic             ph_s;
    logic             step_prev_q;
    logic             step_edge;
    logic [31:0]      idle_cnt_q;
    logic             idle_q;
    logic [FLT_W-1:0] fault_q;
    logic [31:0]      slot_cnt_q;
    logic [3:0]       slot_q;
    logic [2:0]       blinks;
    logic [CUR_W-1:0] standstill_cur;
    logic [CUR_W-1:0] reduced_cur;
    logic [CUR_W+6:0] prod;

    // Step, switch and fault pins are asynchronous to the reference clock; the current code is used unsynchronised
    sicf_sync u_sync_step (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_d(i_step_pulse_input), .o_q(step_s));
    sicf_sync u_sync_sw (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_d(i_standstill_current_select_switch), .o_q(sw_s));
    sicf_sync u_sync_oc (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_d(i_over_current), .o_q(oc_s));
    sicf_sync u_sync_ov (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_d(i_over_voltage), .o_q(ov_s));
    sicf_sync u_sync_ph (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_d(i_phase_error), .o_q(ph_s));

    // Rising edge of the synchronised step input
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            step_prev_q <= 1'b0;
        end else begin
            step_prev_q <= step_s;
        end
    end
    assign step_edge = step_s & ~step_prev_q;

    // Idle timer restarts on each step edge
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            idle_cnt_q <= 32'h0;
            idle_q     <= 1'b0;
        end else if (step_edge) begin
            idle_cnt_q <= 32'h0;
            idle_q     <= 1'b0;
        end else if (idle_cnt_q >= IDLE_CNT - 1) begin
            idle_q     <= 1'b1;
        end else begin
            idle_cnt_q <= idle_cnt_q + 32'h1;
        end
    end

    // Current targets; integer scaling truncates toward zero
    assign prod           = ({7'h0, i_dynamic_current}) * 15'(IDLE_PCT);
    assign reduced_cur    = CUR_W'(prod / 15'(100));
    assign standstill_cur = sw_s ? i_dynamic_current
                                 : (i_dynamic_current >> 1);

    // Running uses full current; idle takes the lower of both limits
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_current_target            <= '0;
            o_standstill_target_q_dummy <= 1'b0;
        end else begin
            o_standstill_target_q_dummy <= idle_q;
            if (!idle_q || step_edge) begin
                o_current_target <= i_dynamic_current;
            end else if (standstill_cur < reduced_cur) begin
                o_current_target <= standstill_cur;
            end else begin
                o_current_target <= reduced_cur;
            end
        end
    end

    // Faults latch; only reset clears them
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_q <= '0;
        end else begin
            fault_q[FLT_OC_BIT] <= fault_q[FLT_OC_BIT] | oc_s;
            fault_q[FLT_OV_BIT] <= fault_q[FLT_OV_BIT] | ov_s;
            fault_q[FLT_PH_BIT] <= fault_q[FLT_PH_BIT] | ph_s;
        end
    end

    // Bridge off while any fault is held
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bridge_enable <= 1'b0;
            o_fault_latched <= '0;
        end else begin
            // Raw synced faults cut the bridge one cycle before the latch
            o_bridge_enable <= ~(|fault_q) &
                               ~(oc_s | ov_s | ph_s);
            o_fault_latched <= fault_q;
        end
    end

    // Priority: over-current, then over-voltage, then phase
    always_comb begin
        blinks = 3'h0;
        if (fault_q[FLT_OC_BIT]) begin
            blinks = 3'(BLINK_OC);
        end else if (fault_q[FLT_OV_BIT]) begin
            blinks = 3'(BLINK_OV);
        end else if (fault_q[FLT_PH_BIT]) begin
            blinks = 3'(BLINK_PH);
        end
    end

    // Period split into equal slots; restarts at first fault
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            slot_cnt_q <= 32'h0;
            slot_q     <= 4'h0;
        end else if (fault_q == '0) begin
            slot_cnt_q <= 32'h0;
            slot_q     <= 4'h0;
        end else if (slot_cnt_q >= SLOT_CNT - 1) begin
            slot_cnt_q <= 32'h0;
            if (slot_q >= 4'(SLOTS_PER_PERIOD - 1)) begin
                slot_q <= 4'h0;
            end else begin
                slot_q <= slot_q + 4'h1;
            end
        end else begin
            slot_cnt_q <= slot_cnt_q + 32'h1;
        end
    end

    // Even slots lit, up to twice the blink count, dark afterwards
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_red_led <= 1'b0;
        end else begin
            o_red_led <= (fault_q != '0) && !slot_q[0] &&
                         ({1'b0, slot_q} < {1'b0, blinks, 1'b0});
        end
    end

    // All checks run on the one clock; reset masks them
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    // A synced fault level seen at the pins
    sequence fault_in_s;
        oc_s || ov_s || ph_s;
    endsequence

    property fault_kept;
        (fault_q != '0) |=> ((fault_q & $past(fault_q)) == $past(fault_q));
    endproperty
    fault_latch_a: assert property (fault_kept)
        else $error("Fault bit cleared without reset");

    property raw_fault_off_p;
        fault_in_s |=> !o_bridge_enable;
    endproperty
    raw_fault_a: assert property (raw_fault_off_p)
        else $error("Bridge enabled with fault present");

    bridge_off_a: assert property (
        (|fault_q) |=> !o_bridge_enable)
        else $error("Bridge enabled during fault");

    run_full_a: assert property (
        step_edge |=> (o_current_target == $past(i_dynamic_current)))
        else $error("Step did not restore full current");

    idle_set_a: assert property (
        (idle_cnt_q == IDLE_CNT - 1 && !step_edge) |=> idle_q)
        else $error("Idle not flagged after timeout");

    prio_oc_a: assert property (
        fault_q[FLT_OC_BIT] |-> blinks == 3'h1)
        else $error("Over-current blink count wrong");

    prio_ov_a: assert property (
        (fault_q == 3'h2) |-> blinks == 3'h2)
        else $error("Over-voltage blink count wrong");

    prio_ph_a: assert property (
        (fault_q == 3'h4) |-> blinks == 3'h4)
        else $error("Phase blink count wrong");

    led_dark_a: assert property (
        (fault_q == '0) |=> !o_red_led)
        else $error("LED lit without fault");

    // Half of the dynamic code is never above 60% of it
    half_cur_a: assert property (
        (idle_q && !step_edge && !sw_s) |=>
        (o_current_target == ($past(i_dynamic_current) >> 1)))
        else $error("Standstill target not half");
endmodule

/* File: sim/sicf_partner.sv */
`timescale 1ns/100ps
// Step controller: each request gives one pulse held high for four cycles
module sicf_partner (
    // Clock
    input  wire logic i_ref_clk,
    // Request from the bench
    input  wire logic i_fire,
    // Step line
    output logic      o_step
);
    logic [2:0] cnt_q = 3'h0;
    // Pulse stretcher; line rests low between pulses like a real controller
    always_ff @(posedge i_ref_clk) begin
        if (i_fire) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    assign o_step = (cnt_q != 3'h0);
endmodule

/* File: sim/tb_sicf_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
n_mismatch++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_sicf_top;
    import sicf_pkg::*;
    // Shortened counts keep the run brief
    localparam int unsigned IDLE = 50;
    localparam int unsigned PER  = 200;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             fire = 1'b0;
    logic             sw = 1'b0;
    logic [CUR_W-1:0] dyn = 8'h64;
    logic [2:0]       flt_in = 3'h0;
    logic             step;
    logic [CUR_W-1:0] tgt;
    logic             idle;
    logic             br;
    logic             led;
    logic [2:0]       flt;
    int               n_mismatch = 0;
    int               comparisons = 0;
    int               cyc = 0;
    sicf_partner u_far (.i_ref_clk(clk), .i_fire(fire), .o_step(step));
    sicf_top #(.IDLE_CNT(IDLE), .PERIOD_CNT(PER)) u_dut (
        .i_ref_clk                         (clk),
        .i_rst                             (rst),
        .i_step_pulse_input                (step),
        .i_standstill_current_select_switch(sw),
        .i_dynamic_current                 (dyn),
        .i_over_current                    (flt_in[0]),
        .i_over_voltage                    (flt_in[1]),
        .i_phase_error                     (flt_in[2]),
        .o_current_target                  (tgt),
        .o_standstill_target_q_dummy       (idle),
        .o_bridge_enable                   (br),
        .o_red_led                         (led),
        .o_fault_latched                   (flt)
    );
    // Clock and hang guard; the tests need about 1400 cycles
    localparam int unsigned LIMIT = 5000;
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Wait n edges, then look while outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Cause removed in the same cycle that reset is raised
    task automatic power();
        @(posedge clk);
        flt_in <= 3'h0;
        rst <= 1'b1;
        settle(3);
        `CHK("bridge in reset", 1'b0, br)
        @(posedge clk);
        rst <= 1'b0;
        settle(2);
        `CHK("bridge after reset", 1'b1, br)
    endtask
    task automatic pulse();
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        settle(8);
        `CHK("target run", dyn, tgt)
        `CHK("idle run", 1'b0, idle)
    endtask
    // Lit cycles and blink count over one full period
    task automatic blink(input int b);
        int lit;
        int edg;
        logic prv;
        lit = 0;
        edg = 0;
        prv = (led === 1'b1);
        repeat (PER) begin
            @(negedge clk);
            if (led === 1'b1) lit++;
            if (led === 1'b1 && !prv) edg++;
            prv = (led === 1'b1);
        end
        `CHK("lit cycles", b * (PER / SLOTS_PER_PERIOD), lit)
        `CHK("blinks", b, edg)
    endtask
    // Fault table: cause, shown blinks
    logic [2:0] fv [5] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h6};
    int         fb [5] = '{1, 2, 4, 1, 2};
    initial begin
        power();
        // Idle reduction for both switch settings; steps restart the timer
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            sw <= s[0];
            // A second dynamic code shows the half rule on another value
            dyn <= s[0] ? 8'h64 : 8'h50;
            pulse();
            settle(IDLE - 15);
            `CHK("idle early", 1'b0, idle)
            pulse();
            settle(IDLE - 15);
            `CHK("idle restart", 1'b0, idle)
            settle(30);
            `CHK("idle flag", 1'b1, idle)
            `CHK("idle target", s ? 8'h3C : 8'h28, tgt)
            pulse();
        end
        // Each fault, then combined faults for priority
        for (int i = 0; i < 5; i++) begin
            power();
            @(posedge clk);
            flt_in <= fv[i];
            settle(6);
            `CHK("bridge fault", 1'b0, br)
            `CHK("led lit first", 1'b1, led)
            `CHK("latched", fv[i], flt)
            @(posedge clk);
            flt_in <= 3'h0;
            settle(5);
            `CHK("still latched", fv[i], flt)
            `CHK("bridge held", 1'b0, br)
            blink(fb[i]);
        end
        final_report();
    end
endmodule
